/* include/apch_pkg.sv */
// package: audio pci config header offsets, fields, reset values, carriers
package apch_pkg;
   // register byte offsets within the header (byte addressing, not all dword aligned)
   localparam logic [7:0] OFF_VENDOR = 8'h00;
   localparam logic [7:0] OFF_DEVICE = 8'h02;
   localparam logic [7:0] OFF_COMMAND = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h06;
   localparam logic [7:0] OFF_REVISION = 8'h08;
   localparam logic [7:0] OFF_PROG_IF = 8'h09;
   localparam logic [7:0] OFF_SUB_CLASS = 8'h0A;
   localparam logic [7:0] OFF_BASE_CLASS = 8'h0B;
   localparam logic [7:0] OFF_HEADER = 8'h0E;
   // dword indexes used by the config port
   localparam logic [5:0] DW_ID = 6'h00;
   localparam logic [5:0] DW_CMD_STS = 6'h01;
   localparam logic [5:0] DW_CLASS = 6'h02;
   localparam logic [5:0] DW_HDR = 6'h03;
   // command word fields
   localparam int CMD_IO_SPACE_BIT = 0;
   localparam int CMD_MEM_SPACE_BIT = 1;
   localparam int CMD_BUS_MASTER_BIT = 2;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   // status word fields
   localparam int STS_MASTER_ABORT_BIT = 13;
   localparam int STS_SEL_TIMING_LO = 9;
   localparam int STS_FAST_B2B_BIT = 7;
   localparam logic [15:0] STS_RESET = 16'h0280;
   localparam logic [1:0] SEL_TIMING_DEFAULT = 2'h1;
   // fixed class bytes
   localparam logic [7:0] PROG_IF_VALUE = 8'h00;
   localparam logic [7:0] SUB_CLASS_VALUE = 8'h01;
   localparam logic [7:0] BASE_CLASS_VALUE = 8'h04;
   localparam logic [7:0] HEADER_LAYOUT_VALUE = 8'h00;
   // identity defaults (arbitrary values)
   localparam logic [15:0] VENDOR_DEFAULT = 16'h1234;
   localparam logic [15:0] DEVICE_DEFAULT = 16'h5678;
   localparam logic [7:0] REVISION_DEFAULT = 8'h01;

   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] dword;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } apch_req_s;

   typedef struct packed {
      logic bus_master_enable;
      logic io_space_enable;
   } apch_ctl_s;
endpackage : apch_pkg

/* rtl/apch_cmd_word.sv */
// command word storage: the two writable enables
`timescale 1ns/1ps
`default_nettype none
module apch_cmd_word
   import apch_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [15:0] wdata,
   input wire logic [1:0] lane_en,
   output apch_ctl_s ctl,
   output logic [15:0] rdata
);
   // ---------------------------------------
   // writable bits live in byte lane 0
   // ---------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl <= '0;
      end else if (wr_en && lane_en[0]) begin
         ctl.bus_master_enable <= wdata[CMD_BUS_MASTER_BIT];
         ctl.io_space_enable <= wdata[CMD_IO_SPACE_BIT];
      end
   end

   // all other bits hardwired zero
   always_comb begin
      rdata = CMD_RESET;
      rdata[CMD_BUS_MASTER_BIT] = ctl.bus_master_enable;
      rdata[CMD_IO_SPACE_BIT] = ctl.io_space_enable;
   end
endmodule : apch_cmd_word
`default_nettype wire

/* rtl/apch_config_header.sv */
// audio pci config header register bank
//
// What this block does
// - fixed 16-bit vendor code at offset zero, writes ignored.
// - command bits 15:10 read zero; bits 9:3 hardwired zero.
// - command bit 2 writable bus master enable; clear disables mastering.
// - command bit 1 memory space hardwired zero; memory accesses never claimed.
// - command bit 0 gates io decode; resets to zero.
// - status bit 13 sets when our master ends with master abort.
// - master abort flag cleared by writing one in byte lane 3, unless an abort arrives the same cycle; zero writes ignored.
// - status bits 15,14,12,11,8,4:0 read zero.
// - status bits 10:9 read-only select timing field.
// - status bit 7 reads one, fast back-to-back capable.
// - status bits 6 and 5 read zero.
// - status word resets to 0280h.
// - read-only 8-bit revision code.
// - sub class byte reads 01h.
// - base class byte reads 04h.
// - header layout byte reads zero.
`timescale 1ns/1ps
`default_nettype none
module apch_config_header
   import apch_pkg::*;
#(
   parameter logic [15:0] VENDOR_CODE = VENDOR_DEFAULT,
   parameter logic [15:0] DEVICE_CODE = DEVICE_DEFAULT,
   parameter logic [7:0] REVISION_CODE = REVISION_DEFAULT,
   parameter logic [1:0] SELECT_TIMING = SEL_TIMING_DEFAULT
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic cfg_valid,
   input wire logic cfg_write,
   input wire logic [5:0] cfg_dword,
   input wire logic [3:0] cfg_byte_en,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ready,
   output logic [31:0] cfg_rdata,
   input wire logic io_hit,
   input wire logic mem_hit,
   output logic io_claim,
   output logic mem_claim,
   input wire logic master_abort_event,
   output logic bus_master_enable,
   output logic io_space_enable
);
   apch_req_s req;
   apch_ctl_s ctl;
   logic [15:0] cmd_rdata;
   logic [15:0] sts_word;
   logic master_abort_reg;
   logic master_abort_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic ready_reg;
   logic cmd_wr;

   // ---------------------------------------
   // dword decode, shared by write and read paths
   // ---------------------------------------
   function automatic logic dword_hit(input logic [5:0] index, input logic [5:0] target);
      return (index == target);
   endfunction : dword_hit

   assign req = '{valid: cfg_valid, write: cfg_write, dword: cfg_dword,
                  byte_en: cfg_byte_en, wdata: cfg_wdata};

   // ---------------------------------------
   // command word
   // ---------------------------------------
   assign cmd_wr = req.valid && req.write && dword_hit(req.dword, DW_CMD_STS);

   apch_cmd_word u_cmd (
      .clk(clk),
      .reset(reset),
      .wr_en(cmd_wr),
      .wdata(req.wdata[15:0]),
      .lane_en(req.byte_en[1:0]),
      .ctl(ctl),
      .rdata(cmd_rdata)
   );

   assign bus_master_enable = ctl.bus_master_enable;
   assign io_space_enable = ctl.io_space_enable;
   assign io_claim = io_hit && ctl.io_space_enable;
   assign mem_claim = 1'b0;

   // ---------------------------------------
   // status word, master abort flag
   // ---------------------------------------
   always_comb begin
      master_abort_next = master_abort_reg;
      if (cmd_wr && req.byte_en[3] && req.wdata[16 + STS_MASTER_ABORT_BIT]) begin
         master_abort_next = 1'b0;
      end
      if (master_abort_event) begin
         master_abort_next = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         master_abort_reg <= STS_RESET[STS_MASTER_ABORT_BIT];
      end else begin
         master_abort_reg <= master_abort_next;
      end
   end

   always_comb begin
      sts_word = '0;
      sts_word[STS_MASTER_ABORT_BIT] = master_abort_reg;
      sts_word[STS_SEL_TIMING_LO +: 2] = SELECT_TIMING;
      sts_word[STS_FAST_B2B_BIT] = 1'b1;
   end

   // ---------------------------------------
   // read path, registered data
   // ---------------------------------------
   always_comb begin
      rdata_next = '0;
      if (dword_hit(req.dword, DW_ID)) begin
         rdata_next = {DEVICE_CODE, VENDOR_CODE};
      end else if (dword_hit(req.dword, DW_CMD_STS)) begin
         rdata_next = {sts_word, cmd_rdata};
      end else if (dword_hit(req.dword, DW_CLASS)) begin
         rdata_next = {BASE_CLASS_VALUE, SUB_CLASS_VALUE, PROG_IF_VALUE,
                       REVISION_CODE};
      end else if (dword_hit(req.dword, DW_HDR)) begin
         rdata_next = {8'h00, HEADER_LAYOUT_VALUE, 16'h0000};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= req.valid;
         if (req.valid && !req.write) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign cfg_ready = ready_reg;
   assign cfg_rdata = rdata_reg;

   // ---------------------------------------
   // checks
   // ---------------------------------------
   chk_abort_sets: assert property (@(posedge clk) disable iff (reset)
      master_abort_event |=> master_abort_reg)
      else $error("master abort flag not set");
   chk_abort_clear: assert property (@(posedge clk) disable iff (reset)
      (cmd_wr && req.byte_en[3] && req.wdata[29] && !master_abort_event) |=> !master_abort_reg)
      else $error("master abort flag not cleared");
   chk_zero_write: assert property (@(posedge clk) disable iff (reset)
      (master_abort_reg && !(cmd_wr && req.wdata[29] && req.byte_en[3])) |=> master_abort_reg)
      else $error("master abort flag lost");
   chk_io_gate: assert property (@(posedge clk) disable iff (reset)
      io_claim |-> io_space_enable)
      else $error("io claimed while disabled");
   chk_mem_never: assert property (@(posedge clk) disable iff (reset)
      !mem_claim)
      else $error("memory access claimed");
   chk_bme_write: assert property (@(posedge clk) disable iff (reset)
      (cmd_wr && req.byte_en[0]) |=> bus_master_enable == $past(req.wdata[2]))
      else $error("bus master enable not written");
   chk_sts_fixed: assert property (@(posedge clk) disable iff (reset)
      (sts_word & 16'hDFFF) == {5'h00, SELECT_TIMING, 9'h080})
      else $error("status fixed bits wrong");
   chk_id_read: assert property (@(posedge clk) disable iff (reset)
      (req.valid && !req.write && req.dword == DW_ID) |=> cfg_rdata == {DEVICE_CODE, VENDOR_CODE})
      else $error("identity read wrong");
   chk_cmd_read: assert property (@(posedge clk) disable iff (reset)
      cmd_rdata[15:3] == 13'h0000 && !cmd_rdata[1])
      else $error("command hardwired bits wrong");
   chk_ready_pulse: assert property (@(posedge clk) disable iff (reset)
      req.valid |=> cfg_ready)
      else $error("access not completed");
   // ---------------------------------------
   // command bits 15:3 hardwired, one check per bit
   // ---------------------------------------
   for (genvar b = 3; b < 16; b++) begin : g_cmd_zero
      chk_cmd_zero_bit: assert property (@(posedge clk) disable iff (reset)
         !cmd_rdata[b])
         else $error("command hardwired bit set");
   end

   // ---------------------------------------
   // further bus and register checks
   // ---------------------------------------
   chk_ios_write: assert property (@(posedge clk) disable iff (reset)
      (cmd_wr && req.byte_en[0]) |=> io_space_enable == $past(req.wdata[0]))
      else $error("io space enable not written");
   chk_bme_hold: assert property (@(posedge clk) disable iff (reset)
      !(cmd_wr && req.byte_en[0]) |=> $stable(bus_master_enable))
      else $error("bus master enable changed without write");
   chk_ios_hold: assert property (@(posedge clk) disable iff (reset)
      !(cmd_wr && req.byte_en[0]) |=> $stable(io_space_enable))
      else $error("io space enable changed without write");
   chk_ready_idle: assert property (@(posedge clk) disable iff (reset)
      !req.valid |=> !cfg_ready)
      else $error("ready without access");
   chk_rdata_hold: assert property (@(posedge clk) disable iff (reset)
      !(req.valid && !req.write) |=> $stable(cfg_rdata))
      else $error("read data changed without read");
   chk_class_read: assert property (@(posedge clk) disable iff (reset)
      (req.valid && !req.write && req.dword == DW_CLASS) |=>
      cfg_rdata == {8'h04, 8'h01, 8'h00, REVISION_CODE})
      else $error("class read wrong");
   chk_hdr_read: assert property (@(posedge clk) disable iff (reset)
      (req.valid && !req.write && req.dword == DW_HDR) |=> cfg_rdata == 32'h0000_0000)
      else $error("header layout read wrong");
   chk_sts_read: assert property (@(posedge clk) disable iff (reset)
      (req.valid && !req.write && req.dword == DW_CMD_STS) |=>
      (cfg_rdata[31:16] & 16'hDFFF) == {5'h00, SELECT_TIMING, 9'h080})
      else $error("status read wrong");
   chk_unmapped_read: assert property (@(posedge clk) disable iff (reset)
      (req.valid && !req.write && req.dword > DW_HDR) |=> cfg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_mem_decode: assert property (@(posedge clk) disable iff (reset)
      mem_hit |-> !mem_claim)
      else $error("memory hit claimed");
   cov_bme_on: cover property (@(posedge clk) disable iff (reset)
      !bus_master_enable ##1 bus_master_enable);
   cov_abort_set_clear: cover property (@(posedge clk) disable iff (reset)
      master_abort_reg ##1 !master_abort_reg);
   cov_abort: cover property (@(posedge clk) disable iff (reset)
      master_abort_event ##[1:20] !master_abort_reg);
   cov_io: cover property (@(posedge clk) disable iff (reset) io_claim);
   cov_read_class: cover property (@(posedge clk) disable iff (reset)
      req.valid && !req.write && req.dword == DW_CLASS);
endmodule : apch_config_header
`default_nettype wire

/* sim/apch_host_model.sv */
// far side model: bus master abort and address decode hits
`timescale 1ns/1ps
`default_nettype none
module apch_host_model (
   input wire logic clk,
   input wire logic abort_cmd,
   input wire logic hit_cmd,
   output logic master_abort_event,
   output logic io_hit,
   output logic mem_hit
);
   initial begin
      master_abort_event = 1'b0;
      io_hit = 1'b0;
      mem_hit = 1'b0;
   end
   // one-cycle abort pulse, decode hits on both spaces
   always @(posedge clk) begin
      master_abort_event <= abort_cmd;
      io_hit <= hit_cmd;
      mem_hit <= hit_cmd;
   end
endmodule : apch_host_model
`default_nettype wire

/* sim/testbench.sv */
// testbench: config header register bank
`timescale 1ns/1ps
`default_nettype none
module testbench import apch_pkg::*;;
   localparam logic [15:0] VEN = 16'hA5C3; // arbitrary value
   localparam logic [15:0] DEV = 16'h3C5A; // arbitrary value
   localparam logic [7:0] REV = 8'h07; // arbitrary value
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cfg_valid = 1'b0;
   logic cfg_write = 1'b0;
   logic [5:0] cfg_dword = 6'h00;
   logic [3:0] cfg_byte_en = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic abort_cmd = 1'b0;
   logic hit_cmd = 1'b0;
   logic cfg_ready, io_hit, mem_hit, io_claim, mem_claim, master_abort_event;
   logic bus_master_enable, io_space_enable;
   logic [31:0] cfg_rdata;
   int mismatches = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   apch_config_header #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV), .REVISION_CODE(REV)) i_dut (
      .clk, .reset, .cfg_valid, .cfg_write, .cfg_dword, .cfg_byte_en, .cfg_wdata, .cfg_ready,
      .cfg_rdata, .io_hit, .mem_hit, .io_claim, .mem_claim, .master_abort_event,
      .bus_master_enable, .io_space_enable);
   apch_host_model i_host (.clk, .abort_cmd, .hit_cmd, .master_abort_event, .io_hit, .mem_hit);
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                         input logic [31:0] wd);
      @(negedge clk);
      cfg_valid = 1'b1;
      cfg_write = wr;
      cfg_dword = dw;
      cfg_byte_en = be;
      cfg_wdata = wd;
      @(negedge clk);
      cfg_valid = 1'b0;
      check("ready", 32'h1, {31'h0, cfg_ready});
   endtask : access
   task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
      access(1'b0, dw, 4'h0, 32'h0);
      check("rdata", exp, cfg_rdata);
   endtask : rd
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      rd(DW_ID, {DEV, VEN});
      rd(DW_CMD_STS, {16'h0280, 16'h0000});
      rd(DW_CLASS, {8'h04, 8'h01, 8'h00, REV});
      rd(DW_HDR, 32'h0);
      rd(6'h20, 32'h0);
      $display("test reset values done");
      for (int d = 0; d < 4; d++) begin
         access(1'b1, d[5:0], 4'hF, 32'hFFFF_FFFF);
      end
      rd(DW_ID, {DEV, VEN});
      rd(DW_CMD_STS, {16'h0280, 16'h0005});
      rd(DW_CLASS, {8'h04, 8'h01, 8'h00, REV});
      rd(DW_HDR, 32'h0);
      check("enables", 32'h3, {30'h0, bus_master_enable, io_space_enable});
      hit_cmd = 1'b1;
      @(negedge clk);
      check("claims", 32'h2, {30'h0, io_claim, mem_claim});
      access(1'b1, DW_CMD_STS, 4'h3, 32'h0);
      check("claims off", 32'h0, {30'h0, io_claim, mem_claim});
      check("enables off", 32'h0, {30'h0, bus_master_enable, io_space_enable});
      hit_cmd = 1'b0;
      $display("test writes and enables done");
      abort_cmd = 1'b1;
      @(negedge clk);
      abort_cmd = 1'b0;
      rd(DW_CMD_STS, {16'h2280, 16'h0000});
      access(1'b1, DW_CMD_STS, 4'hC, 32'h0);
      rd(DW_CMD_STS, {16'h2280, 16'h0000});
      access(1'b1, DW_CMD_STS, 4'h8, 32'h2000_0000);
      rd(DW_CMD_STS, {16'h0280, 16'h0000});
      $display("test master abort done");
      access(1'b1, DW_CMD_STS, 4'h1, 32'h0000_0005);
      reset = 1'b1;
      @(negedge clk);
      check("reset enables", 32'h0, {30'h0, bus_master_enable, io_space_enable});
      reset = 1'b0;
      rd(DW_CMD_STS, {16'h0280, 16'h0000});
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
